/* design/ccl_cal_limit_top.sv */
// Command registers for current gain, per-phase current offset and the overvoltage limit.
// Assumes commands arrive decoded from the serial interface on sys_clk, one per cycle.
//
// Overview of operation
// - Reported current is sensed current multiplied by the gain word; gain resets to one.
// - Gain word: signed exponent bits 15:11 resetting 11001b, signed mantissa 10:0.
// - Offset word: same split, exponent resets to 11100b, both fields writable.
// - Unsupported gain or offset writes are refused, flagged and signalled to host.
// - After power-up, store or restore, gain rounds to nearest 1/64, max 1.984.
// - Each phase keeps its own offset; stack offset is the sum of all.
// - Restore brings offset to a supported value; fine runtime writes within limits accepted.
// - Phase select 00h to 03h writes and reads only that phase's offset.
// - Phase select FFh write gives each phase the written total divided by phases.
// - Phase select FFh read returns phase zero offset times number of phases.
// - Overvoltage fault when sensed voltage exceeds limit, relative to commanded voltage.
// - In absolute format a new voltage command leaves the stored limit word unchanged.
// - Even in absolute format the effective threshold follows the present command.
// - Overvoltage checking runs from reset release, even with conversion disabled.
// - A detected overvoltage fault acts as the programmed fault response selects.
// - Limit is one sixteen-bit unsigned word in the format the output mode picks.
// - Limit rounds up to supported steps, 105 to 140 percent by 2.5 percent.
// - With conversion off only 110 to 140 percent in 10 percent steps exist.
`timescale 1ns/1ps
module ccl_cal_limit_top #(
	parameter int MAX_PHASES = 4
) (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        cmdValid,
	input  wire logic        cmdWrite,
	input  wire logic [7:0]  cmdCode,
	input  wire logic [15:0] cmdData,
	input  wire logic [7:0]  phaseSel,
	input  wire logic [2:0]  numPhases,
	input  wire logic        nvmStore,
	input  wire logic        nvmRestore,
	input  wire logic        clearStatus,
	input  wire logic [15:0] sensedCurrent,
	input  wire logic [15:0] vSense,
	input  wire logic [15:0] voutCommand,
	input  wire logic        voutRelative,
	input  wire logic [3:0]  relFracBits,
	input  wire logic        convEnable,
	input  wire logic [1:0]  ovResponse,
	output logic [15:0]      rdData,
	output logic             rdValid,
	output logic             invalidPulse,
	output logic             invalidFlag,
	output logic [15:0]      reportedCurrent,
	output logic             ovFault,
	output logic             ovShutdown
);
	localparam logic [15:0] GAIN_RST = {ccl_pkg::GAIN_EXP_RST, ccl_pkg::GAIN_MAN_RST};
	localparam logic [15:0] OFS_RST  = {ccl_pkg::OFS_EXP_RST, ccl_pkg::OFS_MAN_RST};
	localparam int          PW       = $clog2(MAX_PHASES);

	logic [15:0]                 gainWord_ff;
	logic [15:0]                 gainShadow_ff;
	logic [15:0]                 limitWord_ff;
	logic [15:0]                 ofsWord_ff[MAX_PHASES];
	logic [15:0]                 ofsShadow_ff[MAX_PHASES];
	logic [MAX_PHASES-1:0][15:0] ofsWords;
	logic                        restoreArm_ff;
	logic [15:0]                 rdData_ff;
	logic                        rdValid_ff;
	logic                        invalidPulse_ff;
	logic                        invalidFlag_ff;
	logic                        isRead;
	logic                        wrGain;
	logic                        wrOfs;
	logic                        wrOv;
	logic                        bcast;
	logic                        single;
	logic                        nvmBusy;
	logic                        restoreFire;
	logic [2:0]                  phaseCnt;
	logic [15:0]                 divWord;
	logic [15:0]                 ofsCand;
	logic signed [47:0]          gainQ;
	logic signed [47:0]          ofsQ;
	logic                        gainOk;
	logic                        ofsOk;
	logic                        badWrite;
	logic signed [13:0]          bcastMan;
	logic [15:0]                 bcastRd;

	ccl_ov_if ovIf();

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	// Command decode
	assign isRead  = cmdValid && !cmdWrite;
	assign wrGain  = cmdValid && cmdWrite && (cmdCode == ccl_pkg::CMD_GAIN);
	assign wrOfs   = cmdValid && cmdWrite && (cmdCode == ccl_pkg::CMD_OFFSET);
	assign wrOv    = cmdValid && cmdWrite && (cmdCode == ccl_pkg::CMD_OV_LIMIT);
	assign bcast   = (phaseSel == ccl_pkg::PHASE_ALL);
	assign single  = (phaseSel <= ccl_pkg::PHASE_TOP);
	assign nvmBusy = restoreFire || nvmStore;

	// A restore runs once after reset release, standing in for the power-up load
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			restoreArm_ff <= 1'b1;
		else
			restoreArm_ff <= 1'b0;
	end

	assign restoreFire = restoreArm_ff || nvmRestore;

	// A stack count of zero or above the build size is read as a single phase
	assign phaseCnt = (numPhases == 3'h0 || numPhases > 3'(MAX_PHASES)) ? 3'h1 : numPhases;

	// Broadcast share keeps the written exponent and divides the mantissa
	assign divWord = {cmdData[15:ccl_pkg::EXP_LSB],
		11'(signed'(cmdData[ccl_pkg::MAN_MSB:0]) / signed'({9'h000, phaseCnt}))};
	assign ofsCand = bcast ? divWord : cmdData;

	// Range checks on the value each word really stands for
	assign gainQ  = ccl_pkg::lin_to_q(cmdData);
	assign ofsQ   = ccl_pkg::lin_to_q(ofsCand);
	assign gainOk = (gainQ >= 48'sh0) && (gainQ <= ccl_pkg::GAIN_Q_MAX);
	assign ofsOk  = (bcast || single) && (ofsQ >= -ccl_pkg::OFS_Q_MAX)
		&& (ofsQ <= ccl_pkg::OFS_Q_MAX);

	// Any refused write raises the invalid-data event
	assign badWrite = (wrGain && !gainOk) || (wrOfs && !ofsOk) || (wrOv && !ovIf.limitOk);

	// Gain word and its stored copy; store and restore both leave the rounded value
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			gainWord_ff   <= GAIN_RST;
			gainShadow_ff <= GAIN_RST;
		end else if (restoreFire) begin
			gainWord_ff <= ccl_pkg::round_gain(gainShadow_ff);
		end else if (nvmStore) begin
			gainShadow_ff <= gainWord_ff;
			gainWord_ff   <= ccl_pkg::round_gain(gainWord_ff);
		end else if (wrGain && gainOk) begin
			gainWord_ff <= cmdData;
		end
	end

	// One offset word per phase, each with its own stored copy
	for (genvar gp = 0; gp < MAX_PHASES; gp++) begin : gPhase
		always_ff @(posedge sys_clk or negedge resetn) begin
			if (!resetn) begin
				ofsWord_ff[gp]   <= OFS_RST;
				ofsShadow_ff[gp] <= OFS_RST;
			end else if (restoreFire) begin
				ofsWord_ff[gp] <= ccl_pkg::round_ofs(ofsShadow_ff[gp]);
			end else if (nvmStore) begin
				ofsShadow_ff[gp] <= ofsWord_ff[gp];
				ofsWord_ff[gp]   <= ccl_pkg::round_ofs(ofsWord_ff[gp]);
			end else if (wrOfs && ofsOk && bcast) begin
				ofsWord_ff[gp] <= divWord;
			end else if (wrOfs && ofsOk && phaseSel[PW-1:0] == PW'(gp)) begin
				ofsWord_ff[gp] <= cmdData;
			end
		end
	end

	// Packed copy for the current path; the registers stay unpacked so that each
	// phase's process owns only its own element
	always_comb begin
		for (int p = 0; p < MAX_PHASES; p++)
			ofsWords[p] = ofsWord_ff[p];
	end

	// Limit word is kept as written; a new voltage command never touches it
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			limitWord_ff <= ccl_pkg::OV_LIMIT_RST;
		else if (wrOv && ovIf.limitOk)
			limitWord_ff <= cmdData;
	end

	// Broadcast read scales phase zero; saturates because the product can outgrow 11 bits
	always_comb begin
		bcastMan = 14'(signed'(ofsWord_ff[0][ccl_pkg::MAN_MSB:0])) * signed'(14'(phaseCnt));
		if (bcastMan > 14'(signed'(ccl_pkg::MAN_POS)))
			bcastRd = {ofsWord_ff[0][15:ccl_pkg::EXP_LSB], ccl_pkg::MAN_POS};
		else if (bcastMan < 14'(signed'(ccl_pkg::MAN_NEG)))
			bcastRd = {ofsWord_ff[0][15:ccl_pkg::EXP_LSB], ccl_pkg::MAN_NEG};
		else
			bcastRd = {ofsWord_ff[0][15:ccl_pkg::EXP_LSB], bcastMan[ccl_pkg::MAN_MSB:0]};
	end

	// Read data one cycle after the request; unknown commands read zero
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rdData_ff  <= 16'h0000;
			rdValid_ff <= 1'b0;
		end else begin
			rdValid_ff <= isRead;
			if (isRead) begin
				case (cmdCode)
					ccl_pkg::CMD_GAIN: begin
						rdData_ff <= gainWord_ff;
					end
					ccl_pkg::CMD_OFFSET: begin
						if (bcast)
							rdData_ff <= bcastRd;
						else if (single)
							rdData_ff <= ofsWord_ff[phaseSel[PW-1:0]];
						else
							rdData_ff <= 16'h0000;
					end
					ccl_pkg::CMD_OV_LIMIT: begin
						rdData_ff <= limitWord_ff;
					end
					default: begin
						rdData_ff <= 16'h0000;
					end
				endcase
			end
		end
	end

	// Invalid-data status; a new event in the clearing cycle wins over the clear
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			invalidPulse_ff <= 1'b0;
			invalidFlag_ff  <= 1'b0;
		end else begin
			invalidPulse_ff <= badWrite;
			if (badWrite)
				invalidFlag_ff <= 1'b1;
			else if (clearStatus)
				invalidFlag_ff <= 1'b0;
		end
	end

	// Overvoltage guard hookup
	assign ovIf.limitCand    = cmdData;
	assign ovIf.limitWr      = wrOv;
	assign ovIf.voutCommand  = voutCommand;
	assign ovIf.voutRelative = voutRelative;
	assign ovIf.relFracBits  = relFracBits;
	assign ovIf.convEnable   = convEnable;
	assign ovIf.vSense       = vSense;
	assign ovIf.ovResponse   = ovResponse;

	ccl_ov_guard u_ccl_ov_guard (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.ovIf    (ovIf.guard)
	);

	ccl_iout_cal #(
		.MAX_PHASES (MAX_PHASES)
	) u_ccl_iout_cal (
		.sys_clk         (sys_clk),
		.resetn          (resetn),
		.sensedCurrent   (sensedCurrent),
		.gainWord        (gainWord_ff),
		.ofsWords        (ofsWords),
		.reportedCurrent (reportedCurrent)
	);

	// Outputs straight from flops
	assign rdData       = rdData_ff;
	assign rdValid      = rdValid_ff;
	assign invalidPulse = invalidPulse_ff;
	assign invalidFlag  = invalidFlag_ff;
	assign ovFault      = ovIf.faultLevel;
	assign ovShutdown   = ovIf.shutdownReq;

	sequence gainWrGood;
		wrGain && gainOk && !nvmBusy;
	endsequence

	sequence bcastWr;
		wrOfs && bcast && ofsOk && !nvmBusy;
	endsequence

	gainStore_a: assert property (gainWrGood |=> gainWord_ff == $past(cmdData))
		else $error("gain write not stored");
	gainReject_a: assert property (wrGain && !gainOk && !nvmBusy |=> $stable(gainWord_ff) && invalidPulse_ff)
		else $error("bad gain write accepted");
	restoreRound_a: assert property (restoreFire |=> gainWord_ff[15:ccl_pkg::EXP_LSB] == ccl_pkg::GAIN_RND_EXP
		&& gainWord_ff[ccl_pkg::MAN_MSB:0] <= ccl_pkg::GAIN_RND_MAX) else $error("restored gain not rounded");
	bcastWrite_a: assert property (bcastWr |=> ofsWord_ff[0] == $past(divWord)
		&& ofsWord_ff[MAX_PHASES-1] == $past(divWord)) else $error("broadcast share missing");
	phaseWrite_a: assert property (wrOfs && single && ofsOk && !nvmBusy && phaseSel[PW-1:0] == '0
		|=> ofsWord_ff[0] == $past(cmdData) && $stable(ofsWord_ff[1])) else $error("phase write leaked");
	bcastRead_a: assert property (isRead && cmdCode == ccl_pkg::CMD_OFFSET && bcast
		|=> rdValid_ff && rdData_ff[15:ccl_pkg::EXP_LSB] == $past(ofsWord_ff[0][15:ccl_pkg::EXP_LSB]))
		else $error("broadcast read exponent wrong");
	flagSetWins_a: assert property (badWrite && clearStatus |=> invalidFlag_ff)
		else $error("invalid event lost to clear");
	limitHold_a: assert property (!(wrOv && ovIf.limitOk) |=> $stable(limitWord_ff))
		else $error("limit word changed without write");

	sequence ofsWrBad;
		wrOfs && !ofsOk && !nvmBusy;
	endsequence

	ofsReject_a: assert property (ofsWrBad |=> invalidPulse_ff && $stable(ofsWord_ff[0]))
		else $error("bad offset write accepted");
	ovReject_a: assert property (wrOv && !ovIf.limitOk |=> invalidPulse_ff && $stable(limitWord_ff))
		else $error("bad limit write accepted");
	flagClear_a: assert property (clearStatus && !badWrite |=> !invalidFlag_ff)
		else $error("invalid flag not cleared");
	ofsRestore_a: assert property (restoreFire |=> ofsWord_ff[0][15:ccl_pkg::EXP_LSB] == ccl_pkg::OFS_RND_EXP
		&& ofsWord_ff[MAX_PHASES-1][15:ccl_pkg::EXP_LSB] == ccl_pkg::OFS_RND_EXP)
		else $error("restored offset not rounded");
	phaseRead_a: assert property (isRead && cmdCode == ccl_pkg::CMD_OFFSET && single
		|=> rdData_ff == $past(ofsWord_ff[phaseSel[PW-1:0]])) else $error("phase read wrong word");
endmodule

/* design/ccl_iout_cal.sv */
// Applies gain and summed per-phase offsets to the sensed output current.
// Assumes sensed current is an unsigned count on sys_clk; result is signed and saturated.
`timescale 1ns/1ps
module ccl_iout_cal #(
	parameter int MAX_PHASES = 4
) (
	input  wire logic                        sys_clk,
	input  wire logic                        resetn,
	input  wire logic [15:0]                 sensedCurrent,
	input  wire logic [15:0]                 gainWord,
	input  wire logic [MAX_PHASES-1:0][15:0] ofsWords,
	output logic [15:0]                      reportedCurrent
);
	logic signed [63:0] prodQ;
	logic signed [63:0] sumQ;
	logic signed [63:0] totQ;
	logic [15:0]        reported_ff;

	// Gain times current, plus the sum of every phase's offset
	always_comb begin
		prodQ = 64'(signed'({1'b0, sensedCurrent})) * 64'(ccl_pkg::lin_to_q(gainWord));
		sumQ  = 64'sh0;
		for (int p = 0; p < MAX_PHASES; p++)
			sumQ = sumQ + 64'(ccl_pkg::lin_to_q(ofsWords[p]));
		totQ = (prodQ + sumQ) >>> ccl_pkg::Q_FRAC;
	end

	// Saturate rather than wrap, so a large offset cannot flip the sign
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			reported_ff <= 16'h0000;
		else if (totQ > ccl_pkg::REP_MAX)
			reported_ff <= 16'h7FFF;
		else if (totQ < ccl_pkg::REP_MIN)
			reported_ff <= 16'h8000;
		else
			reported_ff <= totQ[15:0];
	end

	assign reportedCurrent = reported_ff;
endmodule

/* design/ccl_ov_guard.sv */
// Overvoltage threshold mapping and fault detection.
// Assumes limit writes may be strobed while limitOk is low; only strobes with limitOk high in the same cycle are latched.
`timescale 1ns/1ps
module ccl_ov_guard (
	input wire logic sys_clk,
	input wire logic resetn,
	ccl_ov_if.guard  ovIf
);
	logic [16:0]                      refLevel;
	logic [27:0]                      limitScaled;
	logic [ccl_pkg::FINE_STEPS-1:0]   fits;
	logic [9:0]                       fineCand;
	logic [9:0]                       finePct_ff;
	logic [9:0]                       effPct;
	logic [27:0]                      senseScaled;
	logic [27:0]                      tripLevel;
	logic                             over;
	logic                             fault_ff;
	logic                             shutdown_ff;

	// Reference is the command in absolute mode, unity at the chosen scale in relative mode
	assign refLevel    = ovIf.voutRelative ? (17'h00001 << ovIf.relFracBits) : {1'b0, ovIf.voutCommand};
	assign limitScaled = 28'(ovIf.limitCand) * 28'(ccl_pkg::PCT4_SCALE);

	// One comparator per supported fine step
	for (genvar k = 0; k < ccl_pkg::FINE_STEPS; k++) begin : gStep
		assign fits[k] = limitScaled <= 28'(refLevel) * 28'(ccl_pkg::PCT4_MIN + 10'(k) * ccl_pkg::PCT4_STEP);
	end

	// Smallest step not below the request, so the limit rounds up
	always_comb begin
		fineCand = ccl_pkg::PCT4_MAX;
		for (int k = ccl_pkg::FINE_STEPS - 1; k >= 0; k--) begin
			if (fits[k])
				fineCand = ccl_pkg::PCT4_MIN + 10'(k) * ccl_pkg::PCT4_STEP;
		end
	end

	assign ovIf.limitOk = fits[ccl_pkg::FINE_STEPS-1] && (ovIf.limitCand != 16'h0000);

	// Latching the ratio keeps the trip point tied to the present command later on
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			finePct_ff <= ccl_pkg::PCT4_MAX;
		else if (ovIf.limitWr && ovIf.limitOk)
			finePct_ff <= fineCand;
	end

	// With conversion off only the coarse steps exist; round up to the next one
	always_comb begin
		if (ovIf.convEnable)
			effPct = finePct_ff;
		else
			effPct = 10'((finePct_ff + ccl_pkg::PCT4_COARSE - 10'h001) / ccl_pkg::PCT4_COARSE
				* ccl_pkg::PCT4_COARSE);
	end

	assign senseScaled = 28'(ovIf.vSense) * 28'(ccl_pkg::PCT4_SCALE);
	assign tripLevel   = 28'(ovIf.voutCommand) * 28'(effPct);
	assign over        = senseScaled > tripLevel;

	// Checking runs from reset release, regardless of conversion state
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			fault_ff    <= 1'b0;
			shutdown_ff <= 1'b0;
		end else begin
			fault_ff    <= over;
			shutdown_ff <= over && (ovIf.ovResponse == ccl_pkg::OV_RESP_SHUT_A
				|| ovIf.ovResponse == ccl_pkg::OV_RESP_SHUT_B);
		end
	end

	assign ovIf.faultLevel  = fault_ff;
	assign ovIf.shutdownReq = shutdown_ff;

	ovFault_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		over |=> fault_ff) else $error("overvoltage not flagged");
	ovShutdown_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		shutdown_ff |-> $past(over) && $past(ovIf.ovResponse) != 2'h0) else $error("shutdown without cause");
	coarseStep_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!ovIf.convEnable |-> effPct % ccl_pkg::PCT4_COARSE == 10'h000 && effPct >= finePct_ff)
		else $error("coarse threshold off step");
endmodule

/* design/ccl_ov_if.sv */
// Signals between the register top and the overvoltage guard.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
interface ccl_ov_if;
	logic [15:0] limitCand;
	logic        limitWr;
	logic [15:0] voutCommand;
	logic        voutRelative;
	logic [3:0]  relFracBits;
	logic        convEnable;
	logic [15:0] vSense;
	logic [1:0]  ovResponse;
	logic        limitOk;
	logic        faultLevel;
	logic        shutdownReq;
	modport guard (input limitCand, limitWr, voutCommand, voutRelative, relFracBits, convEnable, vSense,
		ovResponse, output limitOk, faultLevel, shutdownReq);
	modport owner (output limitCand, limitWr, voutCommand, voutRelative, relFracBits, convEnable, vSense,
		ovResponse, input limitOk, faultLevel, shutdownReq);
endinterface

/* design/ccl_pkg.sv */
// Constants, field layout and linear-format helpers for the current calibration and OV limit block.
// Assumes one clock domain; all values here are shared by the top and its two helpers.
package ccl_pkg;
	localparam logic [7:0]  CMD_GAIN     = 8'h38;
	localparam logic [7:0]  CMD_OFFSET   = 8'h39;
	localparam logic [7:0]  CMD_OV_LIMIT = 8'h40;
	localparam logic [7:0]  PHASE_ALL    = 8'hFF;
	localparam logic [7:0]  PHASE_TOP    = 8'h03;
	localparam int          EXP_LSB      = 11;
	localparam int          MAN_MSB      = 10;
	localparam logic [4:0]  GAIN_EXP_RST = 5'h19;
	localparam logic [10:0] GAIN_MAN_RST = 11'h080;
	localparam logic [4:0]  OFS_EXP_RST  = 5'h1C;
	localparam logic [10:0] OFS_MAN_RST  = 11'h000;
	localparam logic [4:0]  GAIN_RND_EXP = 5'h1A;
	localparam logic [10:0] GAIN_RND_MAX = 11'h07F;
	localparam logic [4:0]  OFS_RND_EXP  = 5'h1C;
	localparam logic [10:0] MAN_POS      = 11'h3FF;
	localparam logic [10:0] MAN_NEG      = 11'h400;
	localparam logic [15:0] OV_LIMIT_RST = 16'h0000;
	localparam int          Q_FRAC       = 16;
	localparam int          GAIN_RND_SH  = 10;
	localparam int          OFS_RND_SH   = 12;
	localparam logic signed [47:0] GAIN_R_TOP = 48'sh7F;
	localparam logic signed [47:0] OFS_R_TOP  = 48'sh80;
	localparam logic signed [47:0] GAIN_Q_MAX = GAIN_R_TOP <<< GAIN_RND_SH;
	localparam logic signed [47:0] OFS_Q_MAX  = OFS_R_TOP <<< OFS_RND_SH;
	localparam logic signed [63:0] REP_MAX    = 64'sh7FFF;
	localparam logic signed [63:0] REP_MIN    = -64'sh8000;
	localparam logic [9:0]  PCT4_SCALE   = 10'h190;
	localparam logic [9:0]  PCT4_MIN     = 10'h1A4;
	localparam logic [9:0]  PCT4_STEP    = 10'h00A;
	localparam logic [9:0]  PCT4_MAX     = 10'h230;
	localparam logic [9:0]  PCT4_COARSE  = 10'h028;
	localparam int          FINE_STEPS   = 15;
	localparam logic [1:0]  OV_RESP_SHUT_A = 2'h1;
	localparam logic [1:0]  OV_RESP_SHUT_B = 2'h2;

	// Mantissa times two to the exponent, in fixed point with Q_FRAC fraction bits
	function automatic logic signed [47:0] lin_to_q(input logic [15:0] w);
		logic signed [47:0] m;
		logic [4:0]         sh;
		m  = 48'(signed'(w[MAN_MSB:0]));
		sh = w[15:EXP_LSB] + 5'h10;
		return m <<< sh;
	endfunction

	// Gain kept in NVM only at 1/64 resolution, clamped to the largest supported factor
	function automatic logic [15:0] round_gain(input logic [15:0] w);
		logic signed [47:0] r;
		r = (lin_to_q(w) + (48'sh1 <<< (GAIN_RND_SH - 1))) >>> GAIN_RND_SH;
		if (r < 48'sh0)
			r = 48'sh0;
		if (r > GAIN_R_TOP)
			r = GAIN_R_TOP;
		return {GAIN_RND_EXP, r[MAN_MSB:0]};
	endfunction

	// Offset kept in NVM only at 1/16 resolution within the supported span
	function automatic logic [15:0] round_ofs(input logic [15:0] w);
		logic signed [47:0] r;
		r = (lin_to_q(w) + (48'sh1 <<< (OFS_RND_SH - 1))) >>> OFS_RND_SH;
		if (r < -OFS_R_TOP)
			r = -OFS_R_TOP;
		if (r > OFS_R_TOP)
			r = OFS_R_TOP;
		return {OFS_RND_EXP, r[MAN_MSB:0]};
	endfunction
endpackage

/* test/ccl_cal_limit_top_bench.sv */
// Self-checking bench for the calibration and overvoltage limit registers.
// Assumes MAX_PHASES of 4 and a host model that runs one command per call.
`timescale 1ns/1ps
module ccl_cal_limit_top_bench;
	logic sys_clk = 1'h0, resetn = 1'h0, cmdValid, cmdWrite, nvmStore = 1'h0, nvmRestore = 1'h0;
	logic clearStatus = 1'h0, voutRelative = 1'h0, convEnable = 1'h0, rdValid, invalidPulse;
	logic invalidFlag, ovFault, ovShutdown;
	logic [7:0]  cmdCode, phaseSel = 8'h00;
	logic [2:0]  numPhases = 3'h4;
	logic [3:0]  relFracBits = 4'h0;
	logic [1:0]  ovResponse = 2'h1;
	logic [15:0] cmdData, rdData, reportedCurrent, sensedCurrent = 16'h0000;
	logic [15:0] vSense = 16'h0579, voutCommand = 16'h03E8;
	int          n_mismatch = 0, comparisons = 0;

	ccl_cal_limit_top #(.MAX_PHASES(4)) u_ccl_cal_limit_top (.sys_clk, .resetn, .cmdValid, .cmdWrite,
		.cmdCode, .cmdData, .phaseSel, .numPhases, .nvmStore, .nvmRestore, .clearStatus, .sensedCurrent,
		.vSense, .voutCommand, .voutRelative, .relFracBits, .convEnable, .ovResponse, .rdData, .rdValid,
		.invalidPulse, .invalidFlag, .reportedCurrent, .ovFault, .ovShutdown);
	ccl_host_model u_ccl_host_model (.sys_clk, .cmdValid, .cmdWrite, .cmdCode, .cmdData, .rdData,
		.rdValid, .invalidPulse);

	// 25 MHz clock
	always #20 sys_clk = ~sys_clk;

	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic inv);
		u_ccl_host_model.xfer(1'h1, c, d);
		chk("refusal pulse", 16'(u_ccl_host_model.gotInvalid), 16'(inv));
	endtask

	task automatic rd(input logic [7:0] c, input logic [15:0] e);
		u_ccl_host_model.xfer(1'h0, c, 16'h0000);
		chk("read valid", 16'(u_ccl_host_model.gotValid), 16'h0001);
		chk("read data", u_ccl_host_model.got, e);
	endtask

	// Fault and shutdown are registered, so look one cycle after the new level
	task automatic setv(input logic [15:0] v, input logic f, input logic s);
		@(negedge sys_clk);
		vSense = v;
		@(negedge sys_clk);
		chk("ovFault", 16'(ovFault), 16'(f));
		chk("ovShutdown", 16'(ovShutdown), 16'(s));
	endtask

	task automatic pulse_nvm(input logic restore);
		@(negedge sys_clk);
		{nvmRestore, nvmStore} = restore ? 2'h2 : 2'h1;
		@(negedge sys_clk);
		{nvmRestore, nvmStore} = 2'h0;
	endtask

	task automatic t_reset();
		@(negedge sys_clk);
		chk("ovFault", 16'(ovFault), 16'h0001);
		rd(8'h38, 16'hD040);
		rd(8'h39, 16'hE000);
		rd(8'h40, 16'h0000);
	endtask

	task automatic t_gain();
		wr(8'h38, 16'hD07F, 1'h0);
		wr(8'h38, 16'hD080, 1'h1);
		wr(8'h38, 16'hD7FF, 1'h1);
		rd(8'h38, 16'hD07F);
		chk("invalidFlag", 16'(invalidFlag), 16'h0001);
		// Clear held across a refused write: the new event must win over the clear
		clearStatus = 1'h1;
		wr(8'h38, 16'hD080, 1'h1);
		chk("invalidFlag", 16'(invalidFlag), 16'h0001);
		@(negedge sys_clk);
		clearStatus = 1'h0;
		chk("invalidFlag", 16'(invalidFlag), 16'h0000);
		wr(8'h38, 16'hB801, 1'h0);
		pulse_nvm(1'h0);
		rd(8'h38, 16'hD000);
		wr(8'h38, 16'hD050, 1'h0);
		pulse_nvm(1'h0);
		wr(8'h38, 16'hD060, 1'h0);
		pulse_nvm(1'h1);
		rd(8'h38, 16'hD050);
	endtask

	task automatic t_offset();
		phaseSel = 8'h02;
		wr(8'h39, 16'hE010, 1'h0);
		rd(8'h39, 16'hE010);
		phaseSel = 8'h00;
		rd(8'h39, 16'hE000);
		wr(8'h39, 16'hE008, 1'h0);
		rd(8'h39, 16'hE008);
		phaseSel = 8'hFF;
		wr(8'h39, 16'hE040, 1'h0);
		rd(8'h39, 16'hE040);
		numPhases = 3'h2;
		rd(8'h39, 16'hE020);
		numPhases = 3'h4;
		phaseSel = 8'h03;
		rd(8'h39, 16'hE010);
		phaseSel = 8'h01;
		wr(8'h39, 16'hE090, 1'h1);
		rd(8'h39, 16'hE010);
		phaseSel = 8'h05;
		wr(8'h39, 16'hE000, 1'h1);
		rd(8'h39, 16'h0000);
	endtask

	// Four phases at 1.0 each add 4 to the scaled current
	task automatic t_current();
		wr(8'h38, 16'hD040, 1'h0);
		sensedCurrent = 16'h0064;
		@(negedge sys_clk);
		chk("reportedCurrent", reportedCurrent, 16'h0068);
		wr(8'h38, 16'hD060, 1'h0);
		@(negedge sys_clk);
		chk("reportedCurrent", reportedCurrent, 16'h009A);
	endtask

	// 106 percent rounds up to 107.5; with conversion off it becomes 110
	task automatic t_ov();
		convEnable = 1'h1;
		wr(8'h40, 16'h0424, 1'h0);
		setv(16'h0434, 1'h1, 1'h1);
		setv(16'h0433, 1'h0, 1'h0);
		ovResponse = 2'h0;
		setv(16'h0434, 1'h1, 1'h0);
		ovResponse = 2'h2;
		convEnable = 1'h0;
		setv(16'h044D, 1'h1, 1'h1);
		setv(16'h044C, 1'h0, 1'h0);
		convEnable = 1'h1;
		voutCommand = 16'h07D0;
		rd(8'h40, 16'h0424);
		setv(16'h0867, 1'h1, 1'h1);
		setv(16'h0866, 1'h0, 1'h0);
		// Relative mode, unity 512: 560 is about 109.4 percent and rounds up to 110
		voutRelative = 1'h1;
		relFracBits = 4'h9;
		wr(8'h40, 16'h0000, 1'h1);
		wr(8'h40, 16'h02D0, 1'h1);
		wr(8'h40, 16'h0230, 1'h0);
		setv(16'h0899, 1'h1, 1'h1);
		setv(16'h0898, 1'h0, 1'h0);
		rd(8'h40, 16'h0230);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence after a five cycle reset
	initial begin
		repeat (5) @(negedge sys_clk);
		resetn = 1'h1;
		t_reset();
		t_gain();
		t_offset();
		t_current();
		t_ov();
		summarize();
	end

	// The run needs about a hundred cycles; 3000 means a hang
	initial begin
		#(3000 * 40);
		n_mismatch++;
		summarize();
	end
endmodule

/* test/ccl_host_model.sv */
// Host stand-in that issues one word read or write per call.
// Assumes the device answers a read or a refusal one clock after the command.
`timescale 1ns/1ps
module ccl_host_model (
	input  wire logic        sys_clk,
	output logic             cmdValid,
	output logic             cmdWrite,
	output logic [7:0]       cmdCode,
	output logic [15:0]      cmdData,
	input  wire logic [15:0] rdData,
	input  wire logic        rdValid,
	input  wire logic        invalidPulse
);
	logic [15:0] got;
	logic        gotValid;
	logic        gotInvalid;

	// Idle bus until the first command
	initial begin
		cmdValid = 1'h0;
		cmdWrite = 1'h0;
		cmdCode  = 8'h00;
		cmdData  = 16'h0000;
	end

	// Inputs move on the falling edge; idle data is inverted so stale bits never pass for valid
	task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data);
		@(negedge sys_clk);
		cmdValid = 1'h1;
		cmdWrite = wr;
		cmdCode  = code;
		cmdData  = data;
		@(negedge sys_clk);
		cmdValid   = 1'h0;
		cmdData    = ~data;
		got        = rdData;
		gotValid   = rdValid;
		gotInvalid = invalidPulse;
	endtask
endmodule
